// ---- hes_regs.vh ----
// Purpose: Register indexes, field positions and reset values of the event status bank.
// Assumes: Byte address on the bus is four times the index; data sits in bits 7:0.
// Notes:   Definitions only; included by the event status bank and its helpers.
`ifndef HES_REGS_VH
`define HES_REGS_VH

// Documented event status registers, read only.
`define HES_IDX_SUPPLY        7'h71
`define HES_IDX_OVT           7'h72
`define HES_IDX_SHUT          7'h73
`define HES_IDX_FAN           7'h74

// Live over-temperature state, one bit per source.
`define HES_IDX_OVT_LIVE      7'h79

// Per-source groups of eight indexes, selected by index bits 6:3.
`define HES_GRP_SEL           4'h8
`define HES_GRP_HIGH          4'h9
`define HES_GRP_HYST          4'hA

// Single configuration registers and the interrupt status register.
`define HES_IDX_SHUT_MODE     7'h58
`define HES_IDX_FAN_LIM0      7'h5A
`define HES_IDX_FAN_LIM1      7'h5B
`define HES_IDX_FAN_LIM2      7'h5C
`define HES_IDX_V10_HIGH      7'h60
`define HES_IDX_V10_LOW       7'h61
`define HES_IDX_VBAT_HIGH     7'h62
`define HES_IDX_VBAT_LOW      7'h63
`define HES_IDX_IRQ_STAT      7'h7C
`define HES_IDX_IRQ_MASK      7'h7D

// Temperature input selection codes.
`define HES_SEL_SYSTEM        2'h0
`define HES_SEL_PROCESSOR     2'h1
`define HES_SEL_AUX           2'h2

// Selection reset: sources 1,4,5,6 system, 2 processor, 3 auxiliary.
`define HES_SEL_RST           12'h024

// Reset values of limits, event registers and masks.
`define HES_HIGH_RST          8'h50
`define HES_HYST_RST          8'h4B
`define HES_FAN_LIM_RST       8'hFF
`define HES_VHIGH_RST         8'hFF
`define HES_VLOW_RST          8'h00
`define HES_EVT_RST           8'h00
`define HES_MASK_RST          4'h0

// Interrupt status bit positions.
`define HES_IRQ_SUPPLY        0
`define HES_IRQ_OVT           1
`define HES_IRQ_SHUT          2
`define HES_IRQ_FAN           3

`endif

// ---- hes_ovt_src.v ----
// Purpose: Over-temperature state of one source with high limit and hysteresis.
// Assumes: Temperature and limits are unsigned codes synchronous to clk_i.
// Notes:   The state flop is the output, so it is glitch free.
`timescale 1ns/1ps

module hes_ovt_src #(
  parameter TEMP_W = 8
) (
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire [TEMP_W-1:0] temp_i,
  input  wire [TEMP_W-1:0] high_i,
  input  wire [TEMP_W-1:0] hyst_i,
  output wire              over_o
);

  reg over_reg;

  // Set above the high limit, release only below hysteresis so a reading
  // that dithers around the limit cannot chatter the state.
  always @(posedge clk_i) begin
    if (rst_i) begin
      over_reg <= 1'b0;
    end else if (temp_i > high_i) begin
      over_reg <= 1'b1;
    end else if (temp_i < hyst_i) begin
      over_reg <= 1'b0;
    end
  end

  assign over_o = over_reg;

endmodule

// ---- hes_event_status.v ----
// Purpose: Event status bank of a hardware monitor: supply, over-temperature,
//          shut-down and fan count events, with a classic Wishbone slave.
// Assumes: Readings arrive as synchronous codes; byte address is index times four.
// Notes:   Event registers clear when read; a set in the read cycle survives.
`timescale 1ns/1ps
`include "hes_regs.vh"

// Function
// - Bit 1 of supply event register sets when 1 V supply leaves its limits.
// - Bit 0 of supply event register sets when battery voltage leaves its limits.
// - Four 8-bit read-only event registers at indexes 71h to 74h.
// - Over-temperature register bits 0-5 set when source exceeds high limit outside shut-down mode.
// - Sources one, four, five, six default to the system temperature input.
// - Source two defaults to the processor temperature input.
// - Source three defaults to the auxiliary temperature input.
// - Shut-down register bits 0-5 set on high limit crossing in shut-down mode.
// - Fan register bits 0-2 set when system, processor, auxiliary fan counts exceed limit.
// - Over-temperature state holds until temperature falls below hysteresis.
module hes_event_status #(
  parameter TEMP_W  = 8,
  parameter VOLT_W  = 8,
  parameter COUNT_W = 8,
  parameter N_SRC   = 6,
  parameter N_FAN   = 3
) (
  input  wire               clk_i,
  input  wire               rst_i,
  input  wire               cyc_i,
  input  wire               stb_i,
  input  wire               we_i,
  input  wire [8:0]         adr_i,
  input  wire [3:0]         sel_i,
  input  wire [31:0]        dat_i,
  output wire [31:0]        dat_o,
  output wire               ack_o,
  output wire               irq_o,
  input  wire [TEMP_W-1:0]  system_temp_input_i,
  input  wire [TEMP_W-1:0]  processor_temp_input_i,
  input  wire [TEMP_W-1:0]  auxiliary_temp_input_i,
  input  wire [VOLT_W-1:0]  one_volt_level_i,
  input  wire [VOLT_W-1:0]  battery_level_i,
  input  wire [COUNT_W-1:0] system_fan_tach_i,
  input  wire [COUNT_W-1:0] processor_fan_tach_i,
  input  wire [COUNT_W-1:0] auxiliary_fan_tach_i
);

  // Bus decode: one access per request, answered one cycle later. The
  // registered answer costs a cycle per access but keeps every bus output
  // a flop; masking the decode with ack_reg stops a request that is still
  // held during its answer from being taken a second time.
  reg         ack_reg;
  reg  [31:0] dat_reg;
  wire [6:0]  idx = adr_i[8:2];
  wire        acc = cyc_i & stb_i & ~ack_reg;
  wire        wr  = acc & we_i & sel_i[0];
  wire        rd  = acc & ~we_i;

  // Configuration registers.
  localparam [2*N_SRC-1:0] SEL_RST = `HES_SEL_RST;

  wire [2*N_SRC-1:0]      src_sel_vec;
  wire [TEMP_W*N_SRC-1:0] high_vec;
  wire [TEMP_W*N_SRC-1:0] hyst_vec;
  reg  [N_SRC-1:0]        shut_mode_reg;
  reg  [COUNT_W-1:0]      fan_lim_reg [0:N_FAN-1];
  reg  [VOLT_W-1:0]       v10_high_reg;
  reg  [VOLT_W-1:0]       v10_low_reg;
  reg  [VOLT_W-1:0]       vbat_high_reg;
  reg  [VOLT_W-1:0]       vbat_low_reg;

  // Event, interrupt and output state.
  reg  [7:0]  supply_limit_event_reg;
  reg  [7:0]  overtemp_limit_event_reg;
  reg  [7:0]  overtemp_shutdown_event_reg;
  reg  [7:0]  fan_count_limit_event_reg;
  reg  [3:0]  irq_stat_reg;
  reg  [3:0]  irq_mask_reg;
  reg         irq_reg;

  wire [N_SRC-1:0]   overtemp_source;
  wire [COUNT_W-1:0] fan_count [0:N_FAN-1];

  assign fan_count[0] = system_fan_tach_i;
  assign fan_count[1] = processor_fan_tach_i;
  assign fan_count[2] = auxiliary_fan_tach_i;

  // Per-source selection, limits and hysteresis state. Each slot keeps its
  // own flops and hands them to the packed vectors, so every bit has one driver.
  genvar i;
  generate
    for (i = 0; i < N_SRC; i = i + 1) begin : g_src
      localparam [2:0] SLOT = i;
      reg  [1:0]        sel_reg;
      reg  [TEMP_W-1:0] high_lim_reg;
      reg  [TEMP_W-1:0] hyst_lim_reg;
      reg  [TEMP_W-1:0] temp_sel;
      wire              slot_wr = wr && (idx[2:0] == SLOT);

      // Packed copies feed the read mux.
      assign src_sel_vec[2*i +: 2]        = sel_reg;
      assign high_vec[TEMP_W*i +: TEMP_W] = high_lim_reg;
      assign hyst_vec[TEMP_W*i +: TEMP_W] = hyst_lim_reg;

      // Code 3 falls back to the system input rather than reading nothing.
      always @* begin
        case (sel_reg)
          `HES_SEL_PROCESSOR: temp_sel = processor_temp_input_i;
          `HES_SEL_AUX:       temp_sel = auxiliary_temp_input_i;
          default:            temp_sel = system_temp_input_i;
        endcase
      end

      // Selection resets to each source's default input.
      always @(posedge clk_i) begin
        if (rst_i) begin
          sel_reg      <= SEL_RST[2*i +: 2];
          high_lim_reg <= `HES_HIGH_RST;
          hyst_lim_reg <= `HES_HYST_RST;
        end else if (slot_wr) begin
          if (idx[6:3] == `HES_GRP_SEL) begin
            sel_reg <= dat_i[1:0];
          end
          if (idx[6:3] == `HES_GRP_HIGH) begin
            high_lim_reg <= dat_i[TEMP_W-1:0];
          end
          if (idx[6:3] == `HES_GRP_HYST) begin
            hyst_lim_reg <= dat_i[TEMP_W-1:0];
          end
        end
      end

      hes_ovt_src #(
        .TEMP_W (TEMP_W)
      ) u_src (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .temp_i (temp_sel),
        .high_i (high_lim_reg),
        .hyst_i (hyst_lim_reg),
        .over_o (overtemp_source[i])
      );
    end
  endgenerate

  // Single configuration registers; each fan limit has its own case item.
  // Indexes outside this list fall to the default branch and change nothing.
  integer f;
  always @(posedge clk_i) begin
    if (rst_i) begin
      shut_mode_reg <= {N_SRC{1'b0}};
      v10_high_reg  <= `HES_VHIGH_RST;
      v10_low_reg   <= `HES_VLOW_RST;
      vbat_high_reg <= `HES_VHIGH_RST;
      vbat_low_reg  <= `HES_VLOW_RST;
      irq_mask_reg  <= `HES_MASK_RST;
      for (f = 0; f < N_FAN; f = f + 1) begin
        fan_lim_reg[f] <= `HES_FAN_LIM_RST;
      end
    end else if (wr) begin
      case (idx)
        `HES_IDX_SHUT_MODE: shut_mode_reg <= dat_i[N_SRC-1:0];
        `HES_IDX_FAN_LIM0:  fan_lim_reg[0] <= dat_i[COUNT_W-1:0];
        `HES_IDX_FAN_LIM1:  fan_lim_reg[1] <= dat_i[COUNT_W-1:0];
        `HES_IDX_FAN_LIM2:  fan_lim_reg[2] <= dat_i[COUNT_W-1:0];
        `HES_IDX_V10_HIGH:  v10_high_reg  <= dat_i[VOLT_W-1:0];
        `HES_IDX_V10_LOW:   v10_low_reg   <= dat_i[VOLT_W-1:0];
        `HES_IDX_VBAT_HIGH: vbat_high_reg <= dat_i[VOLT_W-1:0];
        `HES_IDX_VBAT_LOW:  vbat_low_reg  <= dat_i[VOLT_W-1:0];
        `HES_IDX_IRQ_MASK:  irq_mask_reg  <= dat_i[3:0];
        default:            shut_mode_reg <= shut_mode_reg;
      endcase
    end
  end

  // Event sources, assembled at full register width with reserved bits zero.
  // Comparisons are strict, so a reading equal to a limit is still in range.
  wire [7:0] supply_set;
  wire [7:0] ovt_set;
  wire [7:0] shut_set;
  wire [7:0] fan_set;

  assign supply_set[0]   = (battery_level_i > vbat_high_reg) |
                           (battery_level_i < vbat_low_reg);
  assign supply_set[1]   = (one_volt_level_i > v10_high_reg) |
                           (one_volt_level_i < v10_low_reg);
  assign supply_set[7:2] = 6'h00;
  assign ovt_set         = {2'b00, overtemp_source & ~shut_mode_reg};
  assign shut_set        = {2'b00, overtemp_source & shut_mode_reg};

  // Fan counts against their limits, one comparator per input.
  genvar k;
  generate
    for (k = 0; k < N_FAN; k = k + 1) begin : g_fan
      assign fan_set[k] = fan_count[k] > fan_lim_reg[k];
    end
  endgenerate
  assign fan_set[7:N_FAN] = {(8-N_FAN){1'b0}};

  // A read clears its register; the set term is ORed last so an event
  // arriving in the clearing cycle is kept. A condition that still holds
  // re-sets its bit at once, so software only sees a bit fall once the cause
  // has gone; reads of other indexes never disturb an event register.
  wire       clr_supply = rd & (idx == `HES_IDX_SUPPLY);
  wire       clr_ovt    = rd & (idx == `HES_IDX_OVT);
  wire       clr_shut   = rd & (idx == `HES_IDX_SHUT);
  wire       clr_fan    = rd & (idx == `HES_IDX_FAN);
  wire [7:0] supply_next = (clr_supply ? 8'h00 : supply_limit_event_reg) | supply_set;
  wire [7:0] ovt_next    = (clr_ovt ? 8'h00 : overtemp_limit_event_reg) | ovt_set;
  wire [7:0] shut_next   = (clr_shut ? 8'h00 : overtemp_shutdown_event_reg) | shut_set;
  wire [7:0] fan_next    = (clr_fan ? 8'h00 : fan_count_limit_event_reg) | fan_set;

  // New bits in any event register raise the matching interrupt status.
  // Only a bit that was clear counts as new: a persisting cause raises one
  // interrupt, not one per cycle, so a cleared status does not re-fire.
  wire [3:0] irq_evt;
  assign irq_evt[`HES_IRQ_SUPPLY] = |(supply_set & ~supply_limit_event_reg);
  assign irq_evt[`HES_IRQ_OVT]    = |(ovt_set & ~overtemp_limit_event_reg);
  assign irq_evt[`HES_IRQ_SHUT]   = |(shut_set & ~overtemp_shutdown_event_reg);
  assign irq_evt[`HES_IRQ_FAN]    = |(fan_set & ~fan_count_limit_event_reg);

  // Write-one-to-clear status; an event in the same cycle wins over the clear.
  wire [3:0] irq_w1c       = (wr && idx == `HES_IDX_IRQ_STAT) ? dat_i[3:0] : 4'h0;
  wire [3:0] irq_stat_next = (irq_stat_reg & ~irq_w1c) | irq_evt;

  // Event registers ignore bus writes entirely, so a stray write from
  // software cannot hide an event that has not been read yet.
  always @(posedge clk_i) begin
    if (rst_i) begin
      supply_limit_event_reg      <= `HES_EVT_RST;
      overtemp_limit_event_reg    <= `HES_EVT_RST;
      overtemp_shutdown_event_reg <= `HES_EVT_RST;
      fan_count_limit_event_reg   <= `HES_EVT_RST;
      irq_stat_reg                <= 4'h0;
      irq_reg                     <= 1'b0;
    end else begin
      supply_limit_event_reg      <= supply_next;
      overtemp_limit_event_reg    <= ovt_next;
      overtemp_shutdown_event_reg <= shut_next;
      fan_count_limit_event_reg   <= fan_next;
      irq_stat_reg                <= irq_stat_next;
      irq_reg                     <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // Read mux; unmapped indexes read zero and are still acknowledged.
  // Per-source groups fall to the default branch, which picks the slot from
  // the low three index bits; slots past the last source read zero.
  reg [7:0] rdata;
  integer   s;
  always @* begin
    rdata = 8'h00;
    case (idx)
      `HES_IDX_SUPPLY:    rdata = supply_limit_event_reg;
      `HES_IDX_OVT:       rdata = overtemp_limit_event_reg;
      `HES_IDX_SHUT:      rdata = overtemp_shutdown_event_reg;
      `HES_IDX_FAN:       rdata = fan_count_limit_event_reg;
      `HES_IDX_OVT_LIVE:  rdata[N_SRC-1:0] = overtemp_source;
      `HES_IDX_SHUT_MODE: rdata[N_SRC-1:0] = shut_mode_reg;
      `HES_IDX_FAN_LIM0:  rdata[COUNT_W-1:0] = fan_lim_reg[0];
      `HES_IDX_FAN_LIM1:  rdata[COUNT_W-1:0] = fan_lim_reg[1];
      `HES_IDX_FAN_LIM2:  rdata[COUNT_W-1:0] = fan_lim_reg[2];
      `HES_IDX_V10_HIGH:  rdata[VOLT_W-1:0] = v10_high_reg;
      `HES_IDX_V10_LOW:   rdata[VOLT_W-1:0] = v10_low_reg;
      `HES_IDX_VBAT_HIGH: rdata[VOLT_W-1:0] = vbat_high_reg;
      `HES_IDX_VBAT_LOW:  rdata[VOLT_W-1:0] = vbat_low_reg;
      `HES_IDX_IRQ_STAT:  rdata[3:0] = irq_stat_reg;
      `HES_IDX_IRQ_MASK:  rdata[3:0] = irq_mask_reg;
      default: begin
        for (s = 0; s < N_SRC; s = s + 1) begin
          if (idx[2:0] == s[2:0]) begin
            if (idx[6:3] == `HES_GRP_SEL) begin
              rdata[1:0] = src_sel_vec[2*s +: 2];
            end
            if (idx[6:3] == `HES_GRP_HIGH) begin
              rdata[TEMP_W-1:0] = high_vec[TEMP_W*s +: TEMP_W];
            end
            if (idx[6:3] == `HES_GRP_HYST) begin
              rdata[TEMP_W-1:0] = hyst_vec[TEMP_W*s +: TEMP_W];
            end
          end
        end
      end
    endcase
  end

  // Acknowledge one cycle after the request and drop it the next cycle,
  // so a request held only through its answer is not taken twice. The last read value stands on
  // dat_o until the next read, so a slow master can still take it.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= acc;
      if (rd) begin
        dat_reg <= {24'h00_0000, rdata};
      end
    end
  end

  assign dat_o = dat_reg;
  assign ack_o = ack_reg;
  assign irq_o = irq_reg;

endmodule

// ---- hes_event_status_properties.sv ----
// Purpose: Bus and read-data properties of the event status bank.
// Assumes: Index is adr_i[8:2]; one-cycle registered ack.
// Notes:   Reserved bits are checked on every read answer of each event register.
`timescale 1ns/1ps
`include "hes_regs.vh"

module hes_event_status_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [8:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A request the slave has not yet answered, and the read answer it leads to.
  sequence req_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence rd_ack_s(logic [6:0] idx);
    ack_o && !$past(we_i) && ($past(adr_i[8:2]) == idx);
  endsequence

  ack_answer_a: assert property (req_s |=> ack_o)
    else $error("request not answered in the next cycle");
  ack_single_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i && !ack_o))
    else $error("ack without a request");
  dat_stand_a: assert property ($changed(dat_o) |-> ack_o && !$past(we_i))
    else $error("read data changed outside a read answer");
  upper_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000)
    else $error("upper read data bits not zero");
  supply_rsvd_a: assert property (rd_ack_s(`HES_IDX_SUPPLY) |-> dat_o[7:2] == 6'h00)
    else $error("supply register reserved bits set");
  ovt_rsvd_a: assert property (rd_ack_s(`HES_IDX_OVT) |-> dat_o[7:6] == 2'h0)
    else $error("over-temperature register reserved bits set");
  shut_rsvd_a: assert property (rd_ack_s(`HES_IDX_SHUT) |-> dat_o[7:6] == 2'h0)
    else $error("shut-down register reserved bits set");
  fan_rsvd_a: assert property (rd_ack_s(`HES_IDX_FAN) |-> dat_o[7:3] == 5'h00)
    else $error("fan register reserved bits set");
  // Reset must quiet every output, so this one is not disabled by reset.
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !ack_o && !irq_o && dat_o == 0)
    else $error("outputs not quiet after reset");
endmodule

bind hes_event_status hes_event_status_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o)
);

// ---- hes_event_status_tb.sv ----
// Purpose: Self-checking bench of the event status bank over Wishbone.
// Assumes: Limits at reset values unless a test writes them.
// Notes:   Waits of four cycles cover the two-edge event and irq latency.
`timescale 1ns/1ps

module hes_event_status_tb;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i;
  logic [8:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  wire  [31:0] dat_o;
  wire         ack_o, irq_o;
  logic [7:0]  src [0:7];
  logic [7:0]  q;
  int          num_errors, compares, cycles, i;

  hes_event_status u_hes_event_status (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .irq_o(irq_o), .system_temp_input_i(src[0]), .processor_temp_input_i(src[1]),
    .auxiliary_temp_input_i(src[2]), .system_fan_tach_i(src[3]),
    .processor_fan_tach_i(src[4]), .auxiliary_fan_tach_i(src[5]),
    .one_volt_level_i(src[6]), .battery_level_i(src[7])
  );

  // Free-running 100 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Hang guard: the tests need well under two thousand cycles.
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Counts: %0d compares, %0d errors", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One classic cycle; request held until the edge that samples ack high.
  task automatic wb_xfer(input logic [6:0] idx, input logic wr, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= wr;
    sel_i <= 4'h1;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t no ack", $time);
    end
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic settle();
    repeat (4) @(posedge clk_i);
  endtask

  task automatic chk_reg(input logic [6:0] idx, input logic [7:0] exp);
    wb_xfer(idx, 1'b0, 8'h00);
    compares++;
    if (q !== exp) begin
      num_errors++;
      $display("[ERR] %0t index %h read %h expected %h", $time, idx, q, exp);
    end
  endtask

  task automatic chk_irq(input logic exp);
    compares++;
    if (irq_o !== exp) begin
      num_errors++;
      $display("[ERR] %0t irq %b expected %b", $time, irq_o, exp);
    end
  endtask

  // Event seen, held while the cause stays, sticky after it goes, cleared by a read.
  task automatic event_case(input int w, input logic [7:0] on, mid, off,
                            input logic [6:0] idx, input logic [7:0] m, input logic live);
    src[w] <= on;
    settle();
    if (live) chk_reg(7'h79, m);
    src[w] <= mid;
    settle();
    if (live) chk_reg(7'h79, m);
    chk_reg(idx, m);
    src[w] <= off;
    settle();
    if (live) chk_reg(7'h79, 8'h00);
    chk_reg(idx, m);
    chk_reg(idx, 8'h00);
  endtask

  // Main sequence.
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 9'h000;
    sel_i = 4'h0;
    dat_i = 32'h0000_0000;
    num_errors = 0;
    compares = 0;
    cycles = 0;
    for (i = 0; i < 8; i++) src[i] = 8'h00;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_xfer(7'h72, 1'b1, 8'hFF);
    wb_xfer(7'h74, 1'b1, 8'hFF);
    for (i = 0; i < 5; i++) chk_reg(7'h71 + i[6:0], 8'h00);
    chk_reg(7'h30, 8'h00);
    chk_reg(7'h40, 8'h00);
    chk_reg(7'h41, 8'h01);
    chk_reg(7'h42, 8'h02);
    for (i = 3; i < 6; i++) chk_reg(7'h40 + i[6:0], 8'h00);
    $display("test reset done");
    event_case(1, 8'h51, 8'h4C, 8'h4A, 7'h72, 8'h02, 1'b1);
    event_case(2, 8'h51, 8'h4C, 8'h4A, 7'h72, 8'h04, 1'b1);
    event_case(0, 8'h51, 8'h4C, 8'h4A, 7'h72, 8'h39, 1'b1);
    $display("test over-temperature done");
    wb_xfer(7'h58, 1'b1, 8'h3F);
    event_case(0, 8'h51, 8'h4C, 8'h4A, 7'h73, 8'h39, 1'b1);
    chk_reg(7'h72, 8'h00);
    $display("test shut-down done");
    for (i = 0; i < 3; i++) begin
      wb_xfer(7'h5A + i[6:0], 1'b1, 8'h10);
      event_case(3 + i, 8'h11, 8'h11, 8'h00, 7'h74, 8'h01 << i, 1'b0);
    end
    $display("test fan done");
    wb_xfer(7'h61, 1'b1, 8'h20);
    event_case(6, 8'h10, 8'h10, 8'h30, 7'h71, 8'h02, 1'b0);
    wb_xfer(7'h62, 1'b1, 8'h80);
    event_case(7, 8'h81, 8'h81, 8'h00, 7'h71, 8'h01, 1'b0);
    $display("test supply done");
    wb_xfer(7'h7C, 1'b1, 8'h0F);
    settle();
    chk_irq(1'b0);
    wb_xfer(7'h7D, 1'b1, 8'h01);
    src[7] <= 8'h81;
    settle();
    chk_irq(1'b1);
    wb_xfer(7'h7D, 1'b1, 8'h00);
    settle();
    chk_irq(1'b0);
    wb_xfer(7'h7D, 1'b1, 8'h01);
    settle();
    chk_irq(1'b1);
    src[7] <= 8'h00;
    wb_xfer(7'h71, 1'b1, 8'h00);
    chk_reg(7'h71, 8'h01);
    wb_xfer(7'h7C, 1'b1, 8'h01);
    settle();
    chk_irq(1'b0);
    chk_reg(7'h71, 8'h00);
    $display("test interrupt done");
    // Reset in mid-run with a fan event pending must clear state and limits.
    src[3] <= 8'h11;
    wb_xfer(7'h7D, 1'b1, 8'h08);
    settle();
    chk_irq(1'b1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_irq(1'b0);
    chk_reg(7'h74, 8'h00);
    chk_reg(7'h5A, 8'hFF);
    $display("test reset in run done");
    report_and_stop();
  end
endmodule
